// ===== hw/ecs_chip_select.v
`timescale 1ns/1ns
`default_nettype none
`include "ecs_defines.vh"

module ecs_chip_select #(
  parameter E_LOW_CYC = `ECS_E_LOW_CYC,
  parameter E_HIGH_CYC = `ECS_E_HIGH_CYC
) (
  input wire clk,
  input wire nrst,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // on-chip mode and register-block placement, same clock
  input wire mode_expanded,
  input wire [3:0] reg_nibble,
  // cpu bus cycle request
  input wire [15:0] cpu_addr,
  input wire cpu_req,
  output wire cpu_done,
  // expansion bus
  output reg e_clk,
  output reg addr_valid,
  // port g bits 7:4, gpio path from the port logic
  input wire [3:0] gpio_out,
  input wire [3:0] gpio_oe,
  output reg [3:0] pg_out,
  output reg [3:0] pg_oe,
  output reg [3:0] pg_claim
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [7:0] stretch_register;
  reg [7:0] select_control_register;
  reg [7:0] general_base_register;
  reg [7:0] general_size_register;
  reg strap_pend;

  reg wr_pend;
  reg [15:0] wr_idx;
  reg [7:0] rd_byte;

  wire addr_phase;
  wire [15:0] ahb_idx;
  wire idx_ok;

  // ----------------------------------------------------------------
  // select configuration
  // ----------------------------------------------------------------
  wire [3:0] sel_en;
  wire [3:0] sel_pol;
  wire [3:0] sel_av;
  wire [3:0] hit_now;
  wire [3:0] live;
  reg [1:0] next_stretch;
  reg [3:0] hit_cycle;

  wire tm_e_high;
  wire tm_active;
  wire tm_start;
  wire cyc_on;
  wire [3:0] cyc_hit;

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  // zero wait state and always okay; reads are fetched in the address
  // phase, so a read directly behind a write sees the old value
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_phase = hsel & hready & (htrans == `ECS_HTRANS_NONSEQ);
  assign ahb_idx = haddr[17:2];
  assign idx_ok = (haddr[31:18] == 14'h0000);

  always @* begin
    rd_byte = 8'h00;
    if (idx_ok) begin
      case (ahb_idx)
        `ECS_IDX_STRETCH: rd_byte = stretch_register;
        `ECS_IDX_CONTROL: rd_byte = select_control_register;
        `ECS_IDX_BASE: rd_byte = general_base_register & `ECS_MASK_BASE;
        `ECS_IDX_SIZE: rd_byte = general_size_register & `ECS_MASK_SIZE;
        default: rd_byte = 8'h00;
      endcase
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_pend <= 1'b0;
      wr_idx <= 16'h0000;
      hrdata <= 32'h00000000;
    end else begin
      wr_pend <= addr_phase & hwrite & idx_ok;
      if (addr_phase) begin
        wr_idx <= ahb_idx;
      end
      if (addr_phase & ~hwrite) begin
        hrdata <= {24'h000000, rd_byte};
      end
    end
  end

  // program enable follows the mode strap caught the cycle after release
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stretch_register <= `ECS_RST_STRETCH;
      select_control_register <= `ECS_RST_CONTROL;
      general_base_register <= `ECS_RST_BASE;
      general_size_register <= `ECS_RST_SIZE;
      strap_pend <= 1'b1;
    end else begin
      strap_pend <= 1'b0;
      if (strap_pend) begin
        select_control_register[`ECS_CTL_PROG_EN] <= mode_expanded;
      end
      if (wr_pend) begin
        case (wr_idx)
          `ECS_IDX_STRETCH: stretch_register <= hwdata[7:0];
          `ECS_IDX_CONTROL: select_control_register <= hwdata[7:0];
          `ECS_IDX_BASE: general_base_register <= hwdata[7:0] & `ECS_MASK_BASE;
          `ECS_IDX_SIZE: general_size_register <= hwdata[7:0] & `ECS_MASK_SIZE;
          default: general_size_register <= general_size_register;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // per-select enable, polarity and window
  // ----------------------------------------------------------------
  // nothing may claim a pin outside expanded modes
  assign sel_en[`ECS_SEL_IO1] = mode_expanded &
                                select_control_register[`ECS_CTL_IO1_EN];
  assign sel_en[`ECS_SEL_IO2] = mode_expanded &
                                select_control_register[`ECS_CTL_IO2_EN];
  assign sel_en[`ECS_SEL_GEN] = mode_expanded &
                                (general_size_register[`ECS_SIZ_GSIZ] != `ECS_GSIZ_OFF);
  assign sel_en[`ECS_SEL_PROG] = mode_expanded & select_control_register[`ECS_CTL_PROG_EN];

  assign sel_pol[`ECS_SEL_IO1] = select_control_register[`ECS_CTL_IO1_POL];
  assign sel_pol[`ECS_SEL_IO2] = select_control_register[`ECS_CTL_IO2_POL];
  assign sel_pol[`ECS_SEL_GEN] = general_size_register[`ECS_SIZ_GEN_POL];
  assign sel_pol[`ECS_SEL_PROG] = 1'b0;

  assign sel_av[`ECS_SEL_IO1] = general_size_register[`ECS_SIZ_IO1_AV];
  assign sel_av[`ECS_SEL_IO2] = general_size_register[`ECS_SIZ_IO2_AV];
  assign sel_av[`ECS_SEL_GEN] = general_size_register[`ECS_SIZ_GEN_AV];
  assign sel_av[`ECS_SEL_PROG] = 1'b1;

  // ----------------------------------------------------------------
  // address decode of the live cpu address
  // ----------------------------------------------------------------
  ecs_decode u_decode (
    .addr(cpu_addr),
    .reg_nibble(reg_nibble),
    .prog_size(select_control_register[`ECS_CTL_PSIZ]),
    .gen_size(general_size_register[`ECS_SIZ_GSIZ]),
    .gen_base(general_base_register[`ECS_BASE_GA]),
    .prio_gen(select_control_register[`ECS_CTL_PRIO]),
    .prog_en(sel_en[`ECS_SEL_PROG]),
    .hit(hit_now)
  );

  assign live = hit_now & sel_en;

  // stretch of the select that will assert; io selects checked first
  always @* begin
    next_stretch = 2'h0;
    if (live[`ECS_SEL_IO1]) begin
      next_stretch = stretch_register[`ECS_STR_IO1];
    end else if (live[`ECS_SEL_IO2]) begin
      next_stretch = stretch_register[`ECS_STR_IO2];
    end else if (live[`ECS_SEL_GEN]) begin
      next_stretch = stretch_register[`ECS_STR_GEN];
    end else if (live[`ECS_SEL_PROG]) begin
      next_stretch = stretch_register[`ECS_STR_PROG];
    end
  end

  // ----------------------------------------------------------------
  // e clock and bus cycle sequencing
  // ----------------------------------------------------------------
  ecs_eclk #(
    .LOW_CYC(E_LOW_CYC),
    .HIGH_CYC(E_HIGH_CYC)
  ) u_eclk (
    .clk(clk),
    .nrst(nrst),
    .cpu_req(cpu_req),
    .stretch(next_stretch),
    .e_high(tm_e_high),
    .active(tm_active),
    .start(tm_start),
    .done(cpu_done)
  );

  // hits are frozen for the whole bus cycle; a size, base or priority write
  // during the cycle takes effect from the next one, but enable, polarity and
  // address-valid bits act at once and can chop a select mid-cycle
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hit_cycle <= 4'h0;
    end else if (tm_start) begin
      hit_cycle <= hit_now;
    end
  end

  // the first clk of a cycle uses the live decode, so address valid and
  // the selects cover the whole e period instead of starting one clk late
  assign cyc_on = tm_active | tm_start;
  assign cyc_hit = tm_start ? hit_now : hit_cycle;

  // ----------------------------------------------------------------
  // port g pins, retimed together with e so they move in step
  // ----------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      e_clk <= 1'b0;
      addr_valid <= 1'b0;
    end else begin
      e_clk <= tm_e_high;
      addr_valid <= cyc_on;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_pin
      wire asserted;
      // disabled selects leave the pin to the gpio logic
      assign asserted = sel_en[i] & cyc_hit[i] & cyc_on &
                        (sel_av[i] | tm_e_high);
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          pg_out[i] <= 1'b0;
          pg_oe[i] <= 1'b0;
          pg_claim[i] <= 1'b0;
        end else begin
          pg_claim[i] <= sel_en[i];
          pg_out[i] <= sel_en[i] ? (sel_pol[i] ? asserted : ~asserted) : gpio_out[i];
          pg_oe[i] <= sel_en[i] | gpio_oe[i];
        end
      end
    end
  endgenerate

  // hsize is not checked: every access is treated as a whole word
  wire unused_ok;
  assign unused_ok = &{1'b0, hsize, hwdata[31:8], haddr[1:0]};

endmodule // ecs_chip_select
`default_nettype wire

// ===== hw/ecs_defines.vh
`ifndef ECS_DEFINES_VH
`define ECS_DEFINES_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define ECS_IDX_STRETCH 16'h105c
`define ECS_IDX_CONTROL 16'h105d
`define ECS_IDX_BASE 16'h105e
`define ECS_IDX_SIZE 16'h105f

// ----------------------------------------------------------------
// reset values and implemented-bit masks
// ----------------------------------------------------------------
`define ECS_RST_STRETCH 8'h00
`define ECS_RST_CONTROL 8'h00
`define ECS_RST_BASE 8'h00
`define ECS_RST_SIZE 8'h07
`define ECS_MASK_BASE 8'hfc
`define ECS_MASK_SIZE 8'hdf

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ECS_STR_IO1 7:6
`define ECS_STR_IO2 5:4
`define ECS_STR_GEN 3:2
`define ECS_STR_PROG 1:0
`define ECS_CTL_IO1_EN 7
`define ECS_CTL_IO1_POL 6
`define ECS_CTL_IO2_EN 5
`define ECS_CTL_IO2_POL 4
`define ECS_CTL_PRIO 3
`define ECS_CTL_PROG_EN 2
`define ECS_CTL_PSIZ 1:0
`define ECS_BASE_GA 7:2
`define ECS_SIZ_IO1_AV 7
`define ECS_SIZ_IO2_AV 6
`define ECS_SIZ_GEN_POL 4
`define ECS_SIZ_GEN_AV 3
`define ECS_SIZ_GSIZ 2:0

// ----------------------------------------------------------------
// select index, equal to port g bit minus four
// ----------------------------------------------------------------
`define ECS_SEL_IO2 0
`define ECS_SEL_IO1 1
`define ECS_SEL_GEN 2
`define ECS_SEL_PROG 3

// ----------------------------------------------------------------
// decode constants
// ----------------------------------------------------------------
`define ECS_PSIZ_64K 2'h0
`define ECS_PSIZ_32K 2'h1
`define ECS_PSIZ_16K 2'h2
`define ECS_GSIZ_OFF 3'h7
`define ECS_IO1_LOW 12'h060

// ----------------------------------------------------------------
// e clock phase lengths in clk cycles, and ahb codes
// ----------------------------------------------------------------
`define ECS_E_LOW_CYC 2
`define ECS_E_HIGH_CYC 2
`define ECS_HTRANS_NONSEQ 2'h2

`endif

// ===== hw/ecs_decode.v
`timescale 1ns/1ns
`default_nettype none
`include "ecs_defines.vh"

module ecs_decode (
  input wire [15:0] addr,
  input wire [3:0] reg_nibble,
  input wire [1:0] prog_size,
  input wire [2:0] gen_size,
  input wire [5:0] gen_base,
  input wire prio_gen,
  input wire prog_en,
  output wire [3:0] hit
);

  wire in_page;
  wire prog_range;
  wire gen_range;
  wire [5:0] bit_ok;

  assign in_page = (addr[15:12] == reg_nibble);
  assign hit[`ECS_SEL_IO1] = in_page & ~addr[11] & (addr[11:0] >= `ECS_IO1_LOW);
  assign hit[`ECS_SEL_IO2] = in_page & addr[11];

  // program range always ends at the top of memory
  assign prog_range = (prog_size == `ECS_PSIZ_64K) ? 1'b1 :
                      (prog_size == `ECS_PSIZ_32K) ? addr[15] :
                      (prog_size == `ECS_PSIZ_16K) ? (&addr[15:14]) :
                      (&addr[15:13]);

  // base bit 5-k (address bit 15-k) takes part only when the size implies it
  genvar k;
  generate
    for (k = 0; k < 6; k = k + 1) begin : g_cmp
      assign bit_ok[k] = (gen_size <= k) | (addr[15 - k] == gen_base[5 - k]);
    end
  endgenerate

  assign gen_range = (gen_size != `ECS_GSIZ_OFF) & (&bit_ok);

  // overlap resolution: only the winner of program and general is reported
  assign hit[`ECS_SEL_GEN] = gen_range & (prio_gen | ~(prog_en & prog_range));
  assign hit[`ECS_SEL_PROG] = prog_en & prog_range & ~(prio_gen & gen_range);

endmodule // ecs_decode
`default_nettype wire

// ===== hw/ecs_eclk.v
`timescale 1ns/1ns
`default_nettype none
`include "ecs_defines.vh"

module ecs_eclk #(
  parameter LOW_CYC = `ECS_E_LOW_CYC,
  parameter HIGH_CYC = `ECS_E_HIGH_CYC,
  parameter CNT_W = 8
) (
  input wire clk,
  input wire nrst,
  input wire cpu_req,
  input wire [1:0] stretch,
  output reg e_high,
  output reg active,
  output wire start,
  output wire done
);

  localparam ST_LOW = 3'b001;
  localparam ST_HIGH = 3'b010;
  localparam ST_STR = 3'b100;
  localparam integer LOW_LAST_I = LOW_CYC - 1;
  localparam integer HIGH_LAST_I = HIGH_CYC - 1;
  localparam integer PER_LAST_I = LOW_CYC + HIGH_CYC - 1;
  localparam [CNT_W-1:0] LOW_LAST = LOW_LAST_I[CNT_W-1:0];
  localparam [CNT_W-1:0] HIGH_LAST = HIGH_LAST_I[CNT_W-1:0];
  localparam [CNT_W-1:0] PER_LAST = PER_LAST_I[CNT_W-1:0];

  reg [2:0] state;
  reg [CNT_W-1:0] cnt;
  reg [1:0] str_left;
  wire period_end;

  // a bus cycle ends with the last clk of e high, after any stretch periods
  assign period_end = ((state == ST_HIGH) & (cnt == HIGH_LAST) & (str_left == 2'h0)) |
                      ((state == ST_STR) & (cnt == PER_LAST) & (str_left == 2'h1));
  assign done = period_end & active;
  assign start = ((state == ST_LOW) & (cnt == {CNT_W{1'b0}}) & ~active & cpu_req);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_LOW;
      cnt <= {CNT_W{1'b0}};
      str_left <= 2'h0;
      e_high <= 1'b0;
      active <= 1'b0;
    end else begin
      case (state)
        ST_LOW: begin
          if (start) begin
            active <= 1'b1;
            str_left <= stretch;
          end
          if (cnt == LOW_LAST) begin
            state <= ST_HIGH;
            cnt <= {CNT_W{1'b0}};
            e_high <= 1'b1;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        ST_HIGH: begin
          if (cnt != HIGH_LAST) begin
            cnt <= cnt + 1'b1;
          end else if (str_left != 2'h0) begin
            state <= ST_STR;
            cnt <= {CNT_W{1'b0}};
          end else begin
            state <= ST_LOW;
            cnt <= {CNT_W{1'b0}};
            e_high <= 1'b0;
            active <= 1'b0;
          end
        end
        ST_STR: begin
          // e held high one full e period per stretch cycle
          if (cnt != PER_LAST) begin
            cnt <= cnt + 1'b1;
          end else if (str_left != 2'h1) begin
            cnt <= {CNT_W{1'b0}};
            str_left <= str_left - 2'h1;
          end else begin
            state <= ST_LOW;
            cnt <= {CNT_W{1'b0}};
            str_left <= 2'h0;
            e_high <= 1'b0;
            active <= 1'b0;
          end
        end
        default: begin
          state <= ST_LOW;
          cnt <= {CNT_W{1'b0}};
          e_high <= 1'b0;
          active <= 1'b0;
        end
      endcase
    end
  end

endmodule // ecs_eclk
`default_nettype wire

// ===== tb/ecs_chip_select_sva.sv
`timescale 1ns/1ns
`default_nettype none
module ecs_chip_select_sva (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cpu_done,
  input wire logic e_clk,
  input wire logic addr_valid,
  input wire logic mode_expanded,
  input wire logic [3:0] gpio_out,
  input wire logic [3:0] gpio_oe,
  input wire logic [3:0] pg_out,
  input wire logic [3:0] pg_oe,
  input wire logic [3:0] pg_claim
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------------------------------
  // bus cycle steps
  // ----------------------------------------------------------------
  sequence s_lead;
    !e_clk ##1 !e_clk ##1 e_clk;
  endsequence
  sequence s_tail;
    e_clk ##1 e_clk ##1 !e_clk;
  endsequence
  a_done_pulse: assert property (cpu_done |=> !cpu_done)
    else $error("done pulse too long");
  a_done_tail: assert property (cpu_done |-> s_tail)
    else $error("e clock not ending with done");
  a_cycle_lead: assert property ($rose(addr_valid) |-> s_lead)
    else $error("address valid not aligned to e low");
  a_av_span: assert property ($rose(addr_valid) |-> addr_valid [*4])
    else $error("address valid too short");
  a_e_low: assert property ($fell(e_clk) |-> s_lead)
    else $error("e low phase length wrong");
  a_prog_idle: assert property (pg_claim[3] && !addr_valid |-> pg_out[3])
    else $error("program select active outside cycle");
  a_gpio_pass: assert property ($past(nrst) && !pg_claim[1] |->
    pg_out[1] == $past(gpio_out[1]) && pg_oe[1] == $past(gpio_oe[1]))
    else $error("free pin not following port data");
  a_claim_oe: assert property ((pg_oe & pg_claim) == pg_claim)
    else $error("claimed pin not driven");
  a_single_chip: assert property (!mode_expanded [*3] |-> pg_claim == 4'h0)
    else $error("select claimed in single chip mode");
endmodule // ecs_chip_select_sva
`default_nettype wire

// ===== tb/ecs_ext_bus.sv
`timescale 1ns/1ns
`default_nettype none
// records what the external parts see in each bus cycle
module ecs_ext_bus (
  input wire logic clk,
  input wire logic nrst,
  input wire logic e_clk,
  input wire logic addr_valid,
  input wire logic [3:0] pg_out,
  input wire logic [3:0] pg_claim,
  output logic [7:0] ehigh,
  output logic [3:0] lo,
  output logic [3:0] hi,
  output logic [3:0] lo_el,
  output logic [3:0] hi_el
);
  logic av_q;
  logic first;
  logic [3:0] l;
  logic [3:0] h;
  assign first = addr_valid & ~av_q;
  assign l = pg_claim & ~pg_out;
  assign h = pg_claim & pg_out;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      av_q <= 1'b0;
      ehigh <= 8'h00;
      lo <= 4'h0;
      hi <= 4'h0;
      lo_el <= 4'h0;
      hi_el <= 4'h0;
    end else begin
      av_q <= addr_valid;
      if (addr_valid) begin
        // a slow part gets e high extended by the stretch count
        ehigh <= (first ? 8'h00 : ehigh) + {7'h00, e_clk};
        lo <= (first ? 4'h0 : lo) | l;
        hi <= (first ? 4'h0 : hi) | h;
        lo_el <= (first ? 4'h0 : lo_el) | (e_clk ? 4'h0 : l);
        hi_el <= (first ? 4'h0 : hi_el) | (e_clk ? 4'h0 : h);
      end
    end
  end
endmodule // ecs_ext_bus
`default_nettype wire

// ===== tb/test_ecs_chip_select.sv
`timescale 1ns/1ns
`default_nettype none
`include "ecs_defines.vh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_errors++; \
  $display("FAIL %s exp %h got %h", nm, ex, got); end end
module test_ecs_chip_select;
  logic clk = 0, nrst = 0, hsel = 0, hwrite = 0, cpu_req = 0, mode_expanded = 1;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic [15:0] cpu_addr = 0, st;
  logic [3:0] reg_nibble = 4'h1, gpio_out = 4'ha, gpio_oe = 4'h5, pol = 4'h0;
  logic [3:0] pg_out, pg_oe, pg_claim, lo, hi, lo_el, hi_el;
  logic [7:0] ehigh;
  logic hready, hreadyout, hresp, cpu_done, e_clk, addr_valid;
  int n_errors = 0, n_tests = 0, i;
  logic [7:0] rst_v [4] = '{8'h00, 8'h04, 8'h00, 8'h07};
  logic [7:0] msk_v [4] = '{8'hff, 8'hff, 8'hfc, 8'hdf};
  logic [15:0] pb [4] = '{16'h0000, 16'h8000, 16'hc000, 16'he000};
  assign hready = hreadyout;
  always #10 clk = ~clk;
  ecs_chip_select u_ecs_chip_select (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mode_expanded(mode_expanded),
    .reg_nibble(reg_nibble), .cpu_addr(cpu_addr), .cpu_req(cpu_req), .cpu_done(cpu_done),
    .e_clk(e_clk), .addr_valid(addr_valid), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .pg_out(pg_out), .pg_oe(pg_oe), .pg_claim(pg_claim));
  ecs_ext_bus u_ecs_ext_bus (.clk(clk), .nrst(nrst), .e_clk(e_clk), .addr_valid(addr_valid),
    .pg_out(pg_out), .pg_claim(pg_claim), .ehigh(ehigh), .lo(lo), .hi(hi), .lo_el(lo_el),
    .hi_el(hi_el));
  // ----------------------------------------------------------------
  // closing report
  // ----------------------------------------------------------------
  task automatic conclude();
    if (n_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // bus access tasks
  // ----------------------------------------------------------------
  task automatic hwait();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_errors++;
      conclude();
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] wd);
    haddr <= {14'h0, idx, 2'b00};
    htrans <= `ECS_HTRANS_NONSEQ;
    hwrite <= w;
    hsel <= 1'b1;
    hwait();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {24'h0, wd};
    hwait();
    rd = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask
  // one cpu cycle; s < 0 skips the e length check
  task automatic cyc(input logic [15:0] a, input int s, input logic [3:0] act,
      input logic [3:0] early);
    int k;
    logic [7:0] eh;
    eh = 8'(`ECS_E_HIGH_CYC + s * (`ECS_E_LOW_CYC + `ECS_E_HIGH_CYC));
    cpu_addr <= a;
    cpu_req <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (cpu_done !== 1'b1 && k < 200);
    cpu_req <= 1'b0;
    if (k >= 200) begin
      n_errors++;
      conclude();
    end
    repeat (4) @(posedge clk);
    if (s >= 0) `CHK("e high", eh, ehigh)
    `CHK("selects", act, (pol & hi) | (~pol & lo))
    `CHK("early selects", early, (pol & hi_el) | (~pol & lo_el))
  endtask
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    for (i = 0; i < 4; i++) begin
      bus(1'b0, 16'(`ECS_IDX_STRETCH + i), 8'h00);
      `CHK("reset value", {24'h0, rst_v[i]}, rd)
    end
    bus(1'b0, 16'h1060, 8'h00);
    `CHK("unmapped", 32'h0, rd)
    cyc(16'h2000, 0, 4'h8, 4'h8);
    for (i = 0; i < 4; i++) begin
      bus(1'b1, 16'(`ECS_IDX_STRETCH + i), 8'hff);
      bus(1'b0, 16'(`ECS_IDX_STRETCH + i), 8'h00);
      `CHK("masked", {24'h0, msk_v[i]}, rd)
    end
    // program size sweep, general off, program stretch one
    bus(1'b1, `ECS_IDX_STRETCH, 8'h6d);
    bus(1'b1, `ECS_IDX_SIZE, 8'h97);
    for (i = 0; i < 4; i++) begin
      bus(1'b1, `ECS_IDX_CONTROL, 8'(4 + i));
      cyc(pb[i], 1, 4'h8, 4'h8);
      if (i > 0) cyc(pb[i] - 16'h1, 0, 4'h0, 4'h0);
    end
    // io selects and overlap
    pol = 4'h6;
    bus(1'b1, `ECS_IDX_CONTROL, 8'he7);
    bus(1'b1, `ECS_IDX_SIZE, 8'h94);
    bus(1'b1, `ECS_IDX_BASE, 8'hec);
    cyc(16'h1060, 1, 4'h2, 4'h2);
    cyc(16'h105f, 0, 4'h0, 4'h0);
    cyc(16'h1800, 2, 4'h1, 4'h0);
    cyc(16'h1fff, 2, 4'h1, 4'h0);
    cyc(16'he123, 1, 4'h8, 4'h8);
    bus(1'b1, `ECS_IDX_CONTROL, 8'hef);
    cyc(16'he123, 3, 4'h4, 4'h0);
    // general select active low over the whole address-valid time
    pol = 4'h2;
    bus(1'b1, `ECS_IDX_SIZE, 8'h8c);
    cyc(16'he123, 3, 4'h4, 4'h4);
    pol = 4'h6;
    bus(1'b1, `ECS_IDX_SIZE, 8'h97);
    cyc(16'he123, 1, 4'h8, 4'h8);
    // general size sweep, program off
    bus(1'b1, `ECS_IDX_CONTROL, 8'he8);
    bus(1'b1, `ECS_IDX_BASE, 8'he8);
    for (i = 0; i < 7; i++) begin
      bus(1'b1, `ECS_IDX_SIZE, 8'(8'h90 + i));
      st = 16'he800 & ~16'((32'h10000 >> i) - 1);
      cyc(st, 3, 4'h4, 4'h0);
      if (i > 0) cyc(st - 16'h1, 0, 4'h0, 4'h0);
    end
    mode_expanded <= 1'b0;
    cyc(16'h1060, -1, 4'h0, 4'h0);
    `CHK("claim", 4'h0, pg_claim)
    `CHK("gpio", gpio_out, pg_out)
    `CHK("gpio oe", gpio_oe, pg_oe)
    // reset again in single-chip mode: program select comes up off
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    bus(1'b0, `ECS_IDX_CONTROL, 8'h00);
    `CHK("single chip control", 32'h0, rd)
    `CHK("single chip claim", 4'h0, pg_claim)
    conclude();
  end
endmodule // test_ecs_chip_select
bind ecs_chip_select ecs_chip_select_sva u_ecs_chip_select_sva (.clk(clk), .nrst(nrst),
  .cpu_done(cpu_done), .e_clk(e_clk), .addr_valid(addr_valid), .mode_expanded(mode_expanded),
  .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pg_out(pg_out), .pg_oe(pg_oe), .pg_claim(pg_claim));
`default_nettype wire
